// File: design/rbst_params.svh
`ifndef RBST_PARAMS_SVH
`define RBST_PARAMS_SVH

// status codes presented while receive self-test is enabled
`define RBST_CODE_DATA_OK   3'h0
`define RBST_CODE_CMD_OK    3'h1
`define RBST_CODE_LAST_GOOD 3'h2
`define RBST_CODE_RESERVED  3'h3
`define RBST_CODE_LAST_BAD  3'h4
`define RBST_CODE_START     3'h5
`define RBST_CODE_ERROR     3'h6
`define RBST_CODE_WAIT      3'h7

// pattern generator
`define RBST_LFSR_W         9
`define RBST_LFSR_SEED      9'h1ff
`define RBST_LFSR_TAP_HI    8
`define RBST_LFSR_TAP_LO    4
`define RBST_SEQ_LEN        511

// first character of a sequence: data character D0.0
`define RBST_SEQ_FIRST_CHAR 8'h00

// tracking limits
`define RBST_CNT_W          10
`define RBST_DIFF_W         8
`define RBST_ERR_LIMIT      8'sh10
`define RBST_RECENTER_CHARS 4'h9
`define RBST_RECENTER_W     4

`endif

// File: design/rbst_pkg.sv
`include "rbst_params.svh"

package rbst_pkg;

   typedef enum logic [1:0] {
      RBST_ST_START   = 2'b00,
      RBST_ST_WAIT    = 2'b01,
      RBST_ST_COMPARE = 2'b10
   } rbst_state_t;

   // one decoded character as presented by the decoder
   typedef struct packed {
      logic       valid;
      logic       is_cmd;
      logic       viol;
      logic [7:0] data;
   } rbst_char_t;

   typedef struct packed {
      rbst_state_t                       state;
      logic [`RBST_LFSR_W-1:0]           lfsr;
      logic [`RBST_CNT_W-1:0]            count;
      logic signed [`RBST_DIFF_W-1:0]    diff;
      logic [`RBST_RECENTER_W-1:0]       recenter;
      logic [2:0]                        code;
      logic                              code_valid;
   } rbst_regs_t;

endpackage : rbst_pkg

// File: design/rbst_tracker.sv
`include "rbst_params.svh"

// Function
// - while self-test is enabled, status bus reports compare state per char
// - matching data character reports code 000
// - matching command character reports code 001
// - valid final character of a sequence reports code 010
// - invalid final character of a sequence reports code 100
// - enabled but compares not yet begun reports code 101
// - pll out of lock or buffer slip also reports code 101
// - mismatching character during compare reports code 110
// - searching for the sequence start character reports code 111
// - pattern generator steps only after sequence start is detected
// - pll loss of lock forces the start state from any state
// - errors exceeding matches by more than sixteen force the wait state
// - wait state looks for data character D0.0 to begin a sequence
// - buffer slip holds start state for nine character periods
module rbst_tracker #(
   parameter int unsigned SEQ_LEN = `RBST_SEQ_LEN
) (
   // clock and reset
   input  wire logic                 CLK_SYS_I,
   input  wire logic                 SRST_I,
   // control and link condition
   input  wire logic                 BIST_EN_I,
   input  wire logic                 PLL_LOCK_LOST_I,
   input  wire logic                 EBUF_SLIP_I,
   // decoded character stream
   input  wire rbst_pkg::rbst_char_t CHAR_I,
   // status
   output logic [2:0]                RX_STATUS_CODE_O,
   output logic                      RX_STATUS_VALID_O,
   output rbst_pkg::rbst_state_t     STATE_O
);

   localparam logic [`RBST_CNT_W-1:0] LAST_IDX =
      `RBST_CNT_W'(SEQ_LEN - 1);

   rbst_pkg::rbst_regs_t r;
   rbst_pkg::rbst_regs_t next_r;

   logic                          go;
   logic                          first_char;
   logic                          match;
   logic                          last;
   logic [`RBST_LFSR_W-1:0]       lfsr_step;
   logic signed [`RBST_DIFF_W-1:0] diff_upd;

   assign go = BIST_EN_I && !PLL_LOCK_LOST_I && !EBUF_SLIP_I && CHAR_I.valid;
   assign first_char = !CHAR_I.viol && !CHAR_I.is_cmd &&
                       (CHAR_I.data == `RBST_SEQ_FIRST_CHAR);
   // the top lfsr bit doubles as the expected command flag
   assign match = !CHAR_I.viol &&
                  ({CHAR_I.is_cmd, CHAR_I.data} == r.lfsr);
   assign last = (r.count == LAST_IDX);
   assign lfsr_step = {r.lfsr[`RBST_LFSR_W-2:0],
                       r.lfsr[`RBST_LFSR_TAP_HI] ^ r.lfsr[`RBST_LFSR_TAP_LO]};

   // saturate low so a long clean run cannot wrap the tracker
   always_comb begin
      diff_upd = r.diff;
      if (!match) begin
         diff_upd = r.diff + `RBST_DIFF_W'sd1;
      end else if (r.diff != {1'b1, {(`RBST_DIFF_W-1){1'b0}}}) begin
         diff_upd = r.diff - `RBST_DIFF_W'sd1;
      end
   end

   always_comb begin
      next_r = r;
      next_r.code_valid = 1'b0;
      if (!BIST_EN_I) begin
         next_r.state    = rbst_pkg::RBST_ST_START;
         next_r.diff     = '0;
         next_r.recenter = '0;
         next_r.code     = `RBST_CODE_START;
      end else if (PLL_LOCK_LOST_I) begin
         next_r.state      = rbst_pkg::RBST_ST_START;
         next_r.diff       = '0;
         next_r.recenter   = '0;
         next_r.code       = `RBST_CODE_START;
         next_r.code_valid = CHAR_I.valid;
      end else if (EBUF_SLIP_I) begin
         next_r.state      = rbst_pkg::RBST_ST_START;
         next_r.diff       = '0;
         next_r.recenter   = `RBST_RECENTER_CHARS;
         next_r.code       = `RBST_CODE_START;
         next_r.code_valid = CHAR_I.valid;
      end else if (CHAR_I.valid) begin
         next_r.code_valid = 1'b1;
         case (r.state)
            rbst_pkg::RBST_ST_START: begin
               next_r.code = `RBST_CODE_START;
               // hold while the buffer recentres
               if (r.recenter > `RBST_RECENTER_W'd1) begin
                  next_r.recenter = r.recenter - `RBST_RECENTER_W'd1;
               end else begin
                  next_r.recenter = '0;
                  next_r.state    = rbst_pkg::RBST_ST_WAIT;
                  next_r.diff     = '0;
               end
            end
            rbst_pkg::RBST_ST_WAIT: begin
               if (first_char) begin
                  next_r.state = rbst_pkg::RBST_ST_COMPARE;
                  next_r.lfsr  = `RBST_LFSR_SEED;
                  next_r.count = `RBST_CNT_W'd1;
                  next_r.code  = `RBST_CODE_DATA_OK;
               end else begin
                  next_r.code = `RBST_CODE_WAIT;
               end
            end
            rbst_pkg::RBST_ST_COMPARE: begin
               next_r.lfsr  = lfsr_step;
               next_r.count = r.count + `RBST_CNT_W'd1;
               if (last) begin
                  next_r.code  = match ? `RBST_CODE_LAST_GOOD
                                       : `RBST_CODE_LAST_BAD;
                  next_r.state = rbst_pkg::RBST_ST_WAIT;
                  next_r.diff  = '0;
               end else begin
                  if (!match) begin
                     next_r.code = `RBST_CODE_ERROR;
                  end else if (CHAR_I.is_cmd) begin
                     next_r.code = `RBST_CODE_CMD_OK;
                  end else begin
                     next_r.code = `RBST_CODE_DATA_OK;
                  end
                  next_r.diff = diff_upd;
                  if (diff_upd > `RBST_ERR_LIMIT) begin
                     next_r.state = rbst_pkg::RBST_ST_WAIT;
                     next_r.diff  = '0;
                  end
               end
            end
            default: begin
               next_r.state = rbst_pkg::RBST_ST_START;
               next_r.code  = `RBST_CODE_START;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         r <= '{state:      rbst_pkg::RBST_ST_START,
                lfsr:       `RBST_LFSR_SEED,
                count:      '0,
                diff:       '0,
                recenter:   '0,
                code:       `RBST_CODE_START,
                code_valid: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign RX_STATUS_CODE_O  = r.code;
   assign RX_STATUS_VALID_O = r.code_valid;
   assign STATE_O           = r.state;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);

   sequence s_cmp_char;
      go && r.state == rbst_pkg::RBST_ST_COMPARE;
   endsequence

   sequence s_cmp_mid;
      s_cmp_char ##0 !last;
   endsequence

   property p_report_each_char;
      go |=> RX_STATUS_VALID_O;
   endproperty
   a_report_each_char: assert property (p_report_each_char)
      else $error("no status for a presented character");

   property p_data_ok;
      s_cmp_mid ##0 match && !CHAR_I.is_cmd
         |=> RX_STATUS_CODE_O == `RBST_CODE_DATA_OK;
   endproperty
   a_data_ok: assert property (p_data_ok)
      else $error("matching data char not reported as 000");

   property p_cmd_ok;
      s_cmp_mid ##0 match && CHAR_I.is_cmd
         |=> RX_STATUS_CODE_O == `RBST_CODE_CMD_OK;
   endproperty
   a_cmd_ok: assert property (p_cmd_ok)
      else $error("matching command char not reported as 001");

   property p_last;
      s_cmp_char ##0 last |=> RX_STATUS_CODE_O ==
         ($past(match) ? `RBST_CODE_LAST_GOOD : `RBST_CODE_LAST_BAD)
         && STATE_O == rbst_pkg::RBST_ST_WAIT;
   endproperty
   a_last: assert property (p_last)
      else $error("final character status wrong");

   property p_lock_lost;
      BIST_EN_I && PLL_LOCK_LOST_I |=> STATE_O == rbst_pkg::RBST_ST_START
         && RX_STATUS_CODE_O == `RBST_CODE_START;
   endproperty
   a_lock_lost: assert property (p_lock_lost)
      else $error("loss of lock did not force start state");

   property p_error;
      s_cmp_mid ##0 !match |=> RX_STATUS_CODE_O == `RBST_CODE_ERROR;
   endproperty
   a_error: assert property (p_error)
      else $error("mismatch not reported as 110");

   property p_wait_code;
      go && r.state == rbst_pkg::RBST_ST_WAIT && !first_char
         |=> RX_STATUS_CODE_O == `RBST_CODE_WAIT
         && STATE_O == rbst_pkg::RBST_ST_WAIT;
   endproperty
   a_wait_code: assert property (p_wait_code)
      else $error("searching state not reported as 111");

   property p_seq_begin;
      go && r.state == rbst_pkg::RBST_ST_WAIT && first_char
         |=> STATE_O == rbst_pkg::RBST_ST_COMPARE
         && r.lfsr == `RBST_LFSR_SEED;
   endproperty
   a_seq_begin: assert property (p_seq_begin)
      else $error("start character did not begin compare");

   property p_limit;
      s_cmp_mid ##0 !match && r.diff == `RBST_ERR_LIMIT
         |=> STATE_O == rbst_pkg::RBST_ST_WAIT && r.diff == '0;
   endproperty
   a_limit: assert property (p_limit)
      else $error("error excess did not force wait state");

   property p_slip_hold;
      BIST_EN_I && !PLL_LOCK_LOST_I && EBUF_SLIP_I
         |=> r.recenter == `RBST_RECENTER_CHARS
         && STATE_O == rbst_pkg::RBST_ST_START;
   endproperty
   a_slip_hold: assert property (p_slip_hold)
      else $error("slip did not start recentre hold");

   property p_diff_clear;
      STATE_O != rbst_pkg::RBST_ST_COMPARE |-> r.diff == '0;
   endproperty
   a_diff_clear: assert property (p_diff_clear)
      else $error("tracking count not clear outside compare");

   property p_no_reserved;
      RX_STATUS_CODE_O != `RBST_CODE_RESERVED;
   endproperty
   a_no_reserved: assert property (p_no_reserved)
      else $error("reserved code 011 driven");

endmodule : rbst_tracker

// File: sim/rbst_far_tx.sv
module rbst_far_tx (
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            srst_i,
   // sequence control
   input  wire logic            send_i,
   input  wire logic            flip_i,
   // character stream
   output rbst_pkg::rbst_char_t char_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // both ends share the middle clock selection; the pattern only runs
   // while this end is strapped to it
   localparam logic [1:0] CLK_SEL_MID     = 2'h1;
   localparam logic [1:0] RX_CLOCK_SELECT = CLK_SEL_MID;

   logic       run;
   logic [8:0] lfsr;
   logic       first;
   logic [7:0] idle;

   assign run = send_i && (RX_CLOCK_SELECT == CLK_SEL_MID);

   always_ff @(posedge clk_i) begin
      idle <= srst_i ? 8'h5a : idle + 8'h35;
      if (srst_i || !run) begin
         first <= 1'b1;
         lfsr  <= 9'h1ff;
      end else if (first) begin
         first <= 1'b0;
      end else begin
         lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      end
   end

   // idle line keeps moving so a stale character is never mistaken for data
   always_comb begin
      if (!run) begin
         char_o = {1'b0, idle[0], idle[1], idle};
      end else if (first) begin
         char_o = {1'b1, 1'b0, 1'b0, 8'h00};
      end else begin
         char_o = {1'b1, lfsr[8], 1'b0, lfsr[7:0] ^ {7'h00, flip_i}};
      end
   end
endmodule : rbst_far_tx

// File: sim/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int SEQ_LEN = 24;
   localparam rbst_pkg::rbst_char_t D00  = 11'h400;
   localparam rbst_pkg::rbst_char_t BAD  = 11'h500;
   localparam rbst_pkg::rbst_char_t IDLE = 11'h0a5;
   localparam rbst_pkg::rbst_state_t S_ST = rbst_pkg::RBST_ST_START;
   localparam rbst_pkg::rbst_state_t S_WT = rbst_pkg::RBST_ST_WAIT;
   localparam rbst_pkg::rbst_state_t S_CP = rbst_pkg::RBST_ST_COMPARE;

   logic                  clk = 1'b0;
   logic                  srst = 1'b1;
   logic                  en = 1'b0;
   logic                  lock = 1'b0;
   logic                  slip = 1'b0;
   logic                  send = 1'b0;
   logic                  flip = 1'b0;
   logic                  use_model = 1'b0;
   rbst_pkg::rbst_char_t  tb_char = IDLE;
   rbst_pkg::rbst_char_t  far_char;
   rbst_pkg::rbst_char_t  mux_char;
   logic [2:0]            code;
   logic                  valid;
   rbst_pkg::rbst_state_t state;
   int                    n_errors = 0;
   int                    cmp_count = 0;

   always #25 clk = ~clk;
   assign mux_char = use_model ? far_char : tb_char;

   rbst_far_tx far (.clk_i(clk), .srst_i(srst), .send_i(send),
                    .flip_i(flip), .char_o(far_char));

   rbst_tracker #(.SEQ_LEN(SEQ_LEN)) uut (
      .CLK_SYS_I(clk), .SRST_I(srst), .BIST_EN_I(en),
      .PLL_LOCK_LOST_I(lock), .EBUF_SLIP_I(slip), .CHAR_I(mux_char),
      .RX_STATUS_CODE_O(code), .RX_STATUS_VALID_O(valid), .STATE_O(state));

   task chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task look(input logic ev, input logic [2:0] ec,
             input rbst_pkg::rbst_state_t es);
      chk("valid", {2'h0, ev}, {2'h0, valid});
      chk("code", ec, code);
      chk("state", {1'b0, es}, {1'b0, state});
   endtask : look

   // one character, then an idle cycle; answer checked one edge later
   task feed(input rbst_pkg::rbst_char_t c, input logic lk, sl, ev,
             input logic [2:0] ec, input rbst_pkg::rbst_state_t es);
      @(posedge clk);
      tb_char <= c;
      lock <= lk;
      slip <= sl;
      @(posedge clk);
      tb_char <= IDLE;
      lock <= 1'b0;
      slip <= 1'b0;
      #1 look(ev, ec, es);
   endtask : feed

   // whole sequence back to back from the far end, one bad index optional
   task run_seq(input int bad_at);
      rbst_pkg::rbst_char_t c;
      logic [2:0]           ec;
      int                   i;
      @(posedge clk);
      use_model <= 1'b1;
      send <= 1'b1;
      flip <= (bad_at == 0);
      #1;
      for (i = 0; i < SEQ_LEN; i++) begin
         c = far_char;
         @(posedge clk);
         flip <= (i + 1 == bad_at);
         if (i == SEQ_LEN - 1) begin
            send <= 1'b0;
            use_model <= 1'b0;
         end
         #1;
         if (i == 0) ec = 3'h0;
         else if (i == SEQ_LEN - 1) ec = (i == bad_at) ? 3'h4 : 3'h2;
         else if (i == bad_at) ec = 3'h6;
         else ec = c.is_cmd ? 3'h1 : 3'h0;
         look(1'b1, ec, (i == SEQ_LEN - 1) ? S_WT : S_CP);
      end
   endtask : run_seq

   task t_reset;
      #1 look(1'b0, 3'h5, S_ST);
      $display("reset test done");
   endtask : t_reset

   task t_search;
      feed(BAD, 1'b0, 1'b0, 1'b0, 3'h5, S_ST);
      @(posedge clk);
      en <= 1'b1;
      feed(BAD, 1'b0, 1'b0, 1'b1, 3'h5, S_WT);
      feed(BAD, 1'b0, 1'b0, 1'b1, 3'h7, S_WT);
      $display("search test done");
   endtask : t_search

   task t_seq;
      run_seq(-1);
      run_seq(3);
      run_seq(SEQ_LEN - 1);
      $display("sequence test done");
   endtask : t_seq

   task t_lock;
      feed(D00, 1'b0, 1'b0, 1'b1, 3'h0, S_CP);
      feed(BAD, 1'b1, 1'b0, 1'b1, 3'h5, S_ST);
      feed(BAD, 1'b0, 1'b0, 1'b1, 3'h5, S_WT);
      $display("lock test done");
   endtask : t_lock

   task t_slip;
      int k;
      feed(D00, 1'b0, 1'b0, 1'b1, 3'h0, S_CP);
      feed(BAD, 1'b0, 1'b1, 1'b1, 3'h5, S_ST);
      for (k = 0; k < 9; k++) begin
         feed(BAD, 1'b0, 1'b0, 1'b1, 3'h5, (k == 8) ? S_WT : S_ST);
      end
      $display("slip test done");
   endtask : t_slip

   task t_limit;
      int k;
      feed(D00, 1'b0, 1'b0, 1'b1, 3'h0, S_CP);
      for (k = 0; k < 17; k++) begin
         feed(BAD, 1'b0, 1'b0, 1'b1, 3'h6, (k == 16) ? S_WT : S_CP);
      end
      feed(D00, 1'b0, 1'b0, 1'b1, 3'h0, S_CP);
      for (k = 0; k < 16; k++) begin
         feed(BAD, 1'b0, 1'b0, 1'b1, 3'h6, S_CP);
      end
      $display("limit test done");
   endtask : t_limit

   task give_verdict;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_search;
      t_seq;
      t_lock;
      t_slip;
      t_limit;
      give_verdict;
   end
endmodule : testbench
